// ---- rtl/pbet_core.sv ----
// prbs bit error tester core: generator, receiver, error event buffer, timer mux
// What this block does
// (R1) bit error sets error-second flag; second tick clears it by 1 us pulse, counts
// (R2) two low error-second count bits readable; three seconds buffered between reads
// (R3) each block-elapsed gives a 1 us pulse that counts the block counter
// (R4) bit error sets block-error flag, block pulse clears it; 4-bit tally
// (R5) drop-out flag holds until sync flag clear line
// (R6) sync flag set on synchronization, holds until sync flag clear line
// (R7) read of 3000 returns block-error, block and error-second count bits
// (R8) timer select captured from port 2 low bits on rising ale
// (R9) contiguous mode and framed mode using 5 to 8 sequence bits per char
// (R10) framed receive: uart data bits enter receiver through a receive buffer
// (R11) pangram message mode sends processor characters through the uart path
// (R12) clock recovery only in contiguous mode; uart only framed or pangram
// (R13) right-shifting generator, selectable taps, serial from top stage, parallel to uart
// (R14) pattern code 00/01/10/11 picks 2047/511/63/mark, transmit and receive
// (R15) pangram mode passes processor characters instead of sequence data
// (R16) error injection inverts one transmitted bit in every 16 bit clocks, in contiguous mode only; framed chars carry no injected errors
// (R17) feed-forward register predicts next bit, flags mismatch
// (R18) feed-back register copies generator, flags mismatch to received bit
// (R19) sync counter clears on feed-forward error, counts feed-back; low pulse at 1111
// (R20) sync pulse loads feed-forward into feed-back and sets sync flag
// (R21) drop-out after over sixteen bit times without transition, holds sync reset
// (R22) bit error only when both errors coincide
// (R23) out-of-lock from drop-out until sixteen clean bits; blocks bit errors
// (R24) block is 1000 bits or the selected sequence length
// (R25) timer select codes 0..7 map to the listed inputs in order
// (R26) 1 us pulses are the nearest whole count of clock cycles
`timescale 1ns/1ns
module pbet_core (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_wr_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  input wire logic [2:0] port2_i,
  input wire logic ale_i,
  input wire logic pattern_code_low_i,
  input wire logic pattern_code_high_i,
  input wire logic pangram_message_mode_i,
  input wire logic framed_mode_i,
  input wire logic [1:0] data_bits_sel_i,
  input wire logic error_inject_en_i,
  input wire logic sync_flag_clear_i,
  input wire logic block_fixed_i,
  input wire logic tx_bit_tick_i,
  input wire logic rx_bit_tick_i,
  input wire logic rx_data_i,
  input wire logic second_tick_i,
  input wire logic cts_i,
  input wire logic rts_mon_i,
  input wire logic low_batt_i,
  input wire logic start_pulse_i,
  input wire logic dcd_i,
  input wire logic uart_rx_valid_i,
  input wire logic [7:0] uart_rx_data_i,
  output logic uart_rx_ready_o,
  input wire logic uart_tx_ready_i,
  output logic uart_tx_valid_o,
  output logic [7:0] uart_tx_data_o,
  output logic tx_data_o,
  output logic bit_error_o,
  output logic drop_out_flag_o,
  output logic sync_flag_o,
  output logic second_tick_output_o,
  output logic processor_timer_input_o,
  output logic clock_recovery_en_o
);
  pbet_pkg::pbet_pins_t pin_raw, pin_m, pin_s;
  pbet_pkg::pbet_pat_t pat;
  pbet_pkg::pbet_fr_t fr_r;
  pbet_pkg::pbet_evt_t evt;
  logic uart_mode, rbit, rbit_v, ff_err, fb_err, fb_gen, sync_go, drop, oolk, tx_stage;
  logic [10:0] tx_r, ff_r, fb_r, blen, bcnt_r;
  logic [3:0] inj_r, fcnt_r, nbits, rxc_r, rxc_nxt, sync_cnt_r;
  logic [7:0] rxb_r, fchar;
  logic [4:0] idle_r, lock_r;
  logic [4:0] pc_r [2];
  logic [1:0] pstart, pact, esec_r;
  logic [3:0] blk_r, blkerr_r;
  logic sync_n_r, esf_r, bef_r, sec_d_r, ale_d_r, bit_err_r;
  logic [2:0] tsel_r;
  logic [7:0] tsrc;
  logic f_valid, f_ready;
  logic [7:0] f_data;

  // predicted next input bit of a generator holding s
  function automatic logic pred(input logic [10:0] s, input pbet_pkg::pbet_pat_t p);
    unique case (p)
      pbet_pkg::PAT_2047: pred = s[pbet_pkg::T2047A] ^ s[pbet_pkg::T2047B];
      pbet_pkg::PAT_511: pred = s[pbet_pkg::T511A] ^ s[pbet_pkg::T511B];
      pbet_pkg::PAT_63: pred = s[pbet_pkg::T63A] ^ s[pbet_pkg::T63B];
      pbet_pkg::PAT_MARK: pred = 1'b1;
    endcase
  endfunction

  // serial output taken from the top stage of the selected length
  function automatic logic stage(input logic [10:0] s, input pbet_pkg::pbet_pat_t p);
    unique case (p)
      pbet_pkg::PAT_2047: stage = s[pbet_pkg::T2047A];
      pbet_pkg::PAT_511: stage = s[pbet_pkg::T511A];
      pbet_pkg::PAT_63: stage = s[pbet_pkg::T63A];
      pbet_pkg::PAT_MARK: stage = 1'b1;
    endcase
  endfunction

  // every pin from outside the clock domain gets two flops
  assign pin_raw = {rx_data_i, second_tick_i, ale_i, port2_i, dcd_i, start_pulse_i,
                    low_batt_i, rts_mon_i, cts_i};
  for (genvar i = 0; i < pbet_pkg::PIN_W; i++) begin : g_sync
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        pin_m[i] <= 1'b0;
        pin_s[i] <= 1'b0;
      end else begin
        pin_m[i] <= pin_raw[i];
        pin_s[i] <= pin_m[i];
      end
    end
  end

  assign pat = pbet_pkg::pbet_pat_t'({pattern_code_high_i, pattern_code_low_i}); // R14
  assign uart_mode = framed_mode_i | pangram_message_mode_i; // R12
  assign nbits = pbet_pkg::DBITS_MIN + {2'b00, data_bits_sel_i}; // R9
  assign tx_stage = stage(tx_r, pat); // R13

  // transmit generator; in framed mode it stalls while a char waits for the fifo
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_r <= pbet_pkg::TX_SEED;
      inj_r <= '0;
      tx_data_o <= 1'b1;
    end else if (tx_bit_tick_i && !uart_mode) begin
      tx_r <= {pred(tx_r, pat), tx_r[10:1]}; // R13
      inj_r <= inj_r + 4'h1;
      tx_data_o <= stage(tx_r, pat) ^ (error_inject_en_i && inj_r == pbet_pkg::INJ_LAST); // R16
    end else if (tx_bit_tick_i && framed_mode_i && !pangram_message_mode_i
                 && fr_r == pbet_pkg::FR_GEN) begin
      tx_r <= {pred(tx_r, pat), tx_r[10:1]}; // R9
    end else if (uart_mode) begin
      tx_data_o <= 1'b1; // line idles at mark while the uart owns it
    end
  end

  // framed char builder: count n sequence bits, then offer them to the fifo
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fr_r <= pbet_pkg::FR_GEN;
      fcnt_r <= '0;
    end else if (!framed_mode_i || pangram_message_mode_i) begin
      fr_r <= pbet_pkg::FR_GEN;
      fcnt_r <= '0;
    end else begin
      unique case (fr_r)
        pbet_pkg::FR_GEN: if (tx_bit_tick_i) begin
          fcnt_r <= fcnt_r + 4'h1;
          if (fcnt_r + 4'h1 == nbits) fr_r <= pbet_pkg::FR_PUSH; // R9
        end
        pbet_pkg::FR_PUSH: if (f_ready) begin
          fr_r <= pbet_pkg::FR_GEN;
          fcnt_r <= '0;
        end
      endcase
    end
  end

  // oldest of the last n bits lands in bit 0, as the uart sends it first
  assign fchar = tx_r[10:3] >> (pbet_pkg::CHAR_W - nbits); // R13
  always_comb begin
    if (pangram_message_mode_i) begin
      f_valid = cpu_wr_i && cpu_addr_i == pbet_pkg::CHAR_ADDR; // R11 R15
      f_data = cpu_wdata_i;
    end else begin
      f_valid = framed_mode_i && fr_r == pbet_pkg::FR_PUSH;
      f_data = fchar;
    end
  end

  pbet_fifo #(.W(8), .D(pbet_pkg::FIFO_D)) u_txq (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(f_valid),
    .in_ready_o(f_ready),
    .in_data_i(f_data),
    .out_valid_o(uart_tx_valid_o),
    .out_ready_i(uart_tx_ready_i),
    .out_data_o(uart_tx_data_o)
  );

  // receive buffer: one uart char shifted out lsb first on receive ticks
  always_comb begin
    rxc_nxt = rxc_r;
    if (uart_rx_valid_i && uart_rx_ready_o) rxc_nxt = nbits;
    else if (rx_bit_tick_i && rxc_r != 4'h0) rxc_nxt = rxc_r - 4'h1;
  end
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rxb_r <= '0;
      rxc_r <= '0;
      uart_rx_ready_o <= 1'b0;
    end else begin
      rxc_r <= rxc_nxt;
      uart_rx_ready_o <= uart_mode && rxc_nxt == 4'h0; // R10
      if (uart_rx_valid_i && uart_rx_ready_o) rxb_r <= uart_rx_data_i;
      else if (rx_bit_tick_i && rxc_r != 4'h0) rxb_r <= {1'b0, rxb_r[7:1]};
    end
  end

  // receive bit source by mode
  assign rbit_v = rx_bit_tick_i && (!uart_mode || rxc_r != 4'h0); // R10
  assign rbit = uart_mode ? rxb_r[0] : pin_s.rx_data;
  assign ff_err = rbit ^ pred(ff_r, pat); // R17
  assign fb_gen = pred(fb_r, pat);
  assign fb_err = rbit ^ fb_gen; // R18
  assign drop = idle_r > pbet_pkg::DROP_LIM && !pangram_message_mode_i; // R21
  assign oolk = lock_r < pbet_pkg::LOCK_HOLD; // R23
  assign sync_go = rbit_v && fb_err && !ff_err && !drop
                   && sync_cnt_r == pbet_pkg::SYNC_FULL; // R19

  // feed-forward and feed-back registers; the sync pulse reloads feed-back
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ff_r <= '0;
      fb_r <= '0;
    end else begin
      if (rbit_v) ff_r <= {rbit, ff_r[10:1]}; // R17
      if (!sync_n_r) fb_r <= ff_r; // R20
      else if (rbit_v) fb_r <= {fb_gen, fb_r[10:1]}; // R18
    end
  end

  // sync controller, held clear through a drop-out
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_cnt_r <= '0;
      sync_n_r <= 1'b1;
    end else begin
      sync_n_r <= !sync_go; // R19
      if (drop || (rbit_v && ff_err)) sync_cnt_r <= '0; // R19 R21
      else if (rbit_v && fb_err) sync_cnt_r <= sync_cnt_r + 4'h1;
    end
  end

  // transition watch and out-of-lock hold counters, both saturating
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_r <= '0;
      lock_r <= '0;
    end else begin
      if (rbit_v) begin
        if (rbit != ff_r[10]) idle_r <= '0; // R21
        else if (idle_r <= pbet_pkg::DROP_LIM) idle_r <= idle_r + 5'h1;
      end
      // only a drop-out unlocks; feed-forward errors merely extend an unlock,
      // otherwise every injected error would hide the next one
      if (drop || (rbit_v && ff_err && oolk)) lock_r <= '0; // R23
      else if (rbit_v && oolk) lock_r <= lock_r + 5'h1;
    end
  end

  // one-microsecond pulse generators: 0 second clear, 1 block end
  assign pstart = {bcnt_r == blen - 11'h1 && rbit_v, pin_s.second && !sec_d_r};
  for (genvar g = 0; g < 2; g++) begin : g_pulse
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) pc_r[g] <= '0;
      else if (pstart[g]) pc_r[g] <= pbet_pkg::PULSE_CYC; // R26
      else if (pc_r[g] != 5'h0) pc_r[g] <= pc_r[g] - 5'h1;
    end
    assign pact[g] = pc_r[g] != 5'h0;
  end

  // block length by variant and pattern
  always_comb begin
    unique case (pat)
      pbet_pkg::PAT_2047: blen = pbet_pkg::LEN_2047;
      pbet_pkg::PAT_511: blen = pbet_pkg::LEN_511;
      pbet_pkg::PAT_63: blen = pbet_pkg::LEN_63;
      pbet_pkg::PAT_MARK: blen = pbet_pkg::LEN_FIXED;
    endcase
    if (block_fixed_i) blen = pbet_pkg::LEN_FIXED; // R24
  end

  // bit counting timer, error flags and event counters
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bcnt_r <= '0;
      sec_d_r <= 1'b0;
      bit_err_r <= 1'b0;
      esf_r <= 1'b0;
      bef_r <= 1'b0;
      esec_r <= '0;
      blk_r <= '0;
      blkerr_r <= '0;
    end else begin
      sec_d_r <= pin_s.second;
      bit_err_r <= rbit_v && ff_err && fb_err && !oolk; // R22 R23
      if (pstart[1]) bcnt_r <= '0; // R24
      else if (rbit_v) bcnt_r <= bcnt_r + 11'h1;
      // set beats clear so an error in the clearing pulse is not lost
      if (bit_err_r) esf_r <= 1'b1; // R1
      else if (pact[0]) esf_r <= 1'b0;
      if (bit_err_r) bef_r <= 1'b1; // R4
      else if (pact[1]) bef_r <= 1'b0;
      if (pstart[0] && esf_r) esec_r <= esec_r + 2'h1; // R1 R2
      if (pstart[1]) blk_r <= blk_r + 4'h1; // R3
      if (pstart[1] && bef_r) blkerr_r <= blkerr_r + 4'h1; // R4
    end
  end

  // drop-out and sync latches, set wins over the clear line
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drop_out_flag_o <= 1'b0;
      sync_flag_o <= 1'b0;
    end else begin
      if (drop) drop_out_flag_o <= 1'b1; // R5
      else if (sync_flag_clear_i) drop_out_flag_o <= 1'b0;
      if (!sync_n_r) sync_flag_o <= 1'b1; // R6 R20
      else if (sync_flag_clear_i) sync_flag_o <= 1'b0;
    end
  end

  // event byte read; other addresses read zero
  assign evt = '{esec: esec_r, blk: blk_r[2:0], blkerr: blkerr_r[2:0]}; // R7
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) cpu_rdata_o <= '0;
    else if (cpu_rd_i && cpu_addr_i == pbet_pkg::EVT_ADDR) cpu_rdata_o <= evt; // R7
    else cpu_rdata_o <= '0;
  end

  // timer mux: select latched on the synchronised rising ale edge
  assign tsrc = {pin_s.dcd, pin_s.start, pin_s.lowbat, pin_s.rts, pin_s.cts,
                 rx_bit_tick_i, tx_bit_tick_i, bit_err_r}; // R25
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ale_d_r <= 1'b0;
      tsel_r <= '0;
      processor_timer_input_o <= 1'b0;
      second_tick_output_o <= 1'b0;
      bit_error_o <= 1'b0;
      clock_recovery_en_o <= 1'b0;
    end else begin
      ale_d_r <= pin_s.ale;
      if (pin_s.ale && !ale_d_r) tsel_r <= pin_s.sel; // R8
      processor_timer_input_o <= tsrc[tsel_r]; // R25
      second_tick_output_o <= oolk && !pangram_message_mode_i;
      bit_error_o <= bit_err_r;
      clock_recovery_en_o <= !uart_mode; // R12
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_sec_pulse_len: assert property ($rose(pact[0]) |-> ##24 pact[0] ##1 !pact[0]) // R1
    else $error("second clear pulse length wrong");
  a_esec_count: assert property (pstart[0] && esf_r |=> esec_r == 2'($past(esec_r) + 2'h1)) // R2
    else $error("error second not counted");
  a_blk_count: assert property (pstart[1] |=> blk_r == 4'($past(blk_r) + 4'h1)) // R3
    else $error("block not counted");
  a_blkerr_set: assert property (bit_err_r |=> bef_r) // R4
    else $error("block error flag missed");
  a_drop_hold: assert property (drop_out_flag_o && !sync_flag_clear_i |=> drop_out_flag_o) // R5
    else $error("drop-out flag lost");
  a_sync_flag: assert property (!sync_n_r |=> sync_flag_o && fb_r == $past(ff_r)) // R20
    else $error("sync load or flag missing");
  a_sync_one: assert property (!sync_n_r |=> sync_n_r) // R19
    else $error("sync pulse longer than one clock");
  a_evt_read: assert property (cpu_rd_i && cpu_addr_i == pbet_pkg::EVT_ADDR // R7
    |=> cpu_rdata_o == $past(evt))
    else $error("event byte wrong");
  a_tsel_latch: assert property (pin_s.ale && !ale_d_r |=> tsel_r == $past(pin_s.sel)) // R8
    else $error("timer select not latched");
  a_inject_bit: assert property (tx_bit_tick_i && !uart_mode && error_inject_en_i // R16
    && inj_r == pbet_pkg::INJ_LAST |=> tx_data_o != $past(tx_stage))
    else $error("injected bit not inverted");
  a_bit_err_cause: assert property (bit_err_r // R22
    |-> $past(ff_err) && $past(fb_err) && !$past(oolk))
    else $error("bit error without both errors");
  a_drop_lock: assert property (drop |=> oolk) // R23
    else $error("drop-out did not force out of lock");

  c_sync: cover property (!sync_n_r);
  c_bit_err: cover property (bit_err_r);
  c_es_count: cover property (pstart[0] && esf_r);
  c_char_push: cover property (f_valid && f_ready && framed_mode_i);
endmodule

// ---- rtl/pbet_fifo.sv ----
// shift-style fifo whose head and flags are flip-flops
`timescale 1ns/1ns
module pbet_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem_r [D];
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_r[0];
  assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);

  // flags are registered from the next count so they stay honest
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      in_ready_o <= cnt_nxt != CW'(D);
      out_valid_o <= cnt_nxt != '0;
    end
  end

  // each entry moves toward the head on a pop
  for (genvar i = 0; i < D; i++) begin : g_ent
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        mem_r[i] <= '0;
      end else if (pop) begin
        if (push && CW'(i + 1) == cnt_r) mem_r[i] <= in_data_i;
        else if (i < D - 1) mem_r[i] <= mem_r[(i < D - 1) ? i + 1 : i];
      end else if (push && CW'(i) == cnt_r) begin
        mem_r[i] <= in_data_i;
      end
    end
  end
endmodule

// ---- rtl/pbet_pkg.sv ----
// shared constants and types of the prbs bit error tester
package pbet_pkg;
  localparam int CLK_NS = 40;
  localparam int PULSE_NS = 1000;
  // nearest whole cycle count to one microsecond
  localparam int PULSE_CYC_I = (PULSE_NS + CLK_NS / 2) / CLK_NS;
  localparam logic [4:0] PULSE_CYC = 5'(PULSE_CYC_I);
  localparam logic [15:0] EVT_ADDR = 16'h3000;
  localparam logic [15:0] CHAR_ADDR = 16'h5000;
  localparam logic [10:0] TX_SEED = 11'h7ff;
  localparam logic [4:0] DROP_LIM = 5'h10;
  localparam logic [4:0] LOCK_HOLD = 5'h10;
  localparam logic [3:0] SYNC_FULL = 4'hf;
  localparam logic [3:0] INJ_LAST = 4'hf;
  localparam logic [3:0] DBITS_MIN = 4'h5;
  localparam logic [3:0] CHAR_W = 4'h8;
  localparam logic [10:0] LEN_FIXED = 11'h3e8;
  localparam logic [10:0] LEN_2047 = 11'h7ff;
  localparam logic [10:0] LEN_511 = 11'h1ff;
  localparam logic [10:0] LEN_63 = 11'h03f;
  // tap stages of the right-shifting generators, index 0 is the oldest stage
  localparam int T2047A = 0;
  localparam int T2047B = 2;
  localparam int T511A = 2;
  localparam int T511B = 6;
  localparam int T63A = 5;
  localparam int T63B = 6;
  localparam int FIFO_D = 4;
  typedef enum logic [1:0] {
    PAT_2047 = 2'b00, PAT_511 = 2'b01, PAT_63 = 2'b10, PAT_MARK = 2'b11
  } pbet_pat_t;
  typedef enum logic {FR_GEN = 1'b0, FR_PUSH = 1'b1} pbet_fr_t;
  typedef struct packed {
    logic [1:0] esec;
    logic [2:0] blk;
    logic [2:0] blkerr;
  } pbet_evt_t;
  typedef struct packed {
    logic rx_data;
    logic second;
    logic ale;
    logic [2:0] sel;
    logic dcd;
    logic start;
    logic lowbat;
    logic rts;
    logic cts;
  } pbet_pins_t;
  localparam int PIN_W = $bits(pbet_pins_t);
endpackage

// ---- verif/pbet_line_model.sv ----
// line under test: loops transmit data back, can hold the line idle
`timescale 1ns/1ns
module pbet_line_model #(
  parameter int DLY = 4
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic tx_tick_i,
  input wire logic tx_data_i,
  input wire logic hold_i,
  output logic rx_data_o,
  output logic rx_tick_o
);
  logic [7:0] tick_sr_r;
  // receive tick lands mid-bit, after the transmit flop and the sync flops
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) tick_sr_r <= 8'h00;
    else tick_sr_r <= {tick_sr_r[6:0], tx_tick_i};
  end
  assign rx_tick_o = (tick_sr_r[DLY-1] === 1'b1);
  // a held line sits at space, so the receiver sees no transitions
  assign rx_data_o = hold_i ? 1'b0 : tx_data_i;
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the prbs bit error tester core
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, ale = 1'b0, pang = 1'b0;
  logic frm = 1'b0, inj = 1'b0, sclr = 1'b0, sec = 1'b0, urx_v = 1'b0, utx_r = 1'b0;
  logic txt = 1'b0, hold = 1'b0, run = 1'b0, bfix = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdat = 8'h00, urx_d = 8'h00, rdata, utx_d;
  logic [7:0] q[$];
  logic [2:0] p2 = 3'h0;
  logic [1:0] pat = 2'b00, dsel = 2'b00;
  logic [4:0] pins = 5'h00;
  logic rxd, rxt, rdy, utx_v, txd, berr, drop, syn, olk, tin, cre;
  int errors = 0, num_checks = 0, seed = 69498, ntick = 0, nbe = 0, cyc = 0, k;

  pbet_core dut (.clock_i(clk), .sys_rst_i(rst), .cpu_addr_i(addr), .cpu_rd_i(rd),
    .cpu_wr_i(wr), .cpu_wdata_i(wdat), .cpu_rdata_o(rdata), .port2_i(p2), .ale_i(ale),
    .pattern_code_low_i(pat[0]), .pattern_code_high_i(pat[1]), .pangram_message_mode_i(pang),
    .framed_mode_i(frm), .data_bits_sel_i(dsel), .error_inject_en_i(inj),
    .sync_flag_clear_i(sclr), .block_fixed_i(bfix), .tx_bit_tick_i(txt), .rx_bit_tick_i(rxt),
    .rx_data_i(rxd), .second_tick_i(sec), .cts_i(pins[0]), .rts_mon_i(pins[1]),
    .low_batt_i(pins[2]), .start_pulse_i(pins[3]), .dcd_i(pins[4]), .uart_rx_valid_i(urx_v),
    .uart_rx_data_i(urx_d), .uart_rx_ready_o(rdy), .uart_tx_ready_i(utx_r),
    .uart_tx_valid_o(utx_v), .uart_tx_data_o(utx_d), .tx_data_o(txd), .bit_error_o(berr),
    .drop_out_flag_o(drop), .sync_flag_o(syn), .second_tick_output_o(olk),
    .processor_timer_input_o(tin), .clock_recovery_en_o(cre));
  pbet_line_model #(.DLY(4)) lm (.clock_i(clk), .sys_rst_i(rst), .tx_tick_i(txt),
    .tx_data_i(txd), .hold_i(hold), .rx_data_o(rxd), .rx_tick_o(rxt));

  initial begin
    forever #20 clk = ~clk;
  end
  // one bit every 8 clocks keeps the line sample clear of the sync delay
  always @(negedge clk) begin
    txt <= run && (cyc % 8 == 0);
    if (run && cyc % 8 == 0) ntick++;
    if (berr === 1'b1) nbe++;
    cyc++;
    if (cyc > 40000) begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdat = d;
    rd = !w;
    wr = w;
    @(negedge clk);
    rd = 1'b0;
    wr = 1'b0;
  endtask
  task automatic upto(input int n);
    while (ntick < n) @(negedge clk);
  endtask
  // clear pulse empties both status flags
  task automatic clr();
    sclr = 1'b1;
    @(negedge clk);
    sclr = 1'b0;
    @(negedge clk);
    chk({6'h00, drop, syn}, 8'h00);
  endtask
  function automatic logic [7:0] evt(input int es, input int bl, input int be);
    pbet_pkg::pbet_evt_t e;
    e.esec = 2'(es);
    e.blk = 3'(bl);
    e.blkerr = 3'(be);
    return e;
  endfunction
  // blocks completed after n received bits, by variant and pattern
  function automatic int nblk(input int n);
    int len;
    len = bfix ? 1000 : (pat == 2'b00 ? 2047 : (pat == 2'b01 ? 511 : 63));
    return n / len;
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    pat = 2'(($random(seed) & 32'h7fff) % 3);
    bfix = 1'($random(seed));
    repeat (4) @(negedge clk);
    acc(1'b0, pbet_pkg::EVT_ADDR, 8'h00);
    chk(rdata, 8'h00);
    acc(1'b0, 16'h3001, 8'h00);
    chk(rdata, 8'h00);
    chk({7'h00, cre}, 8'h01);
    // two random levels behind each static mux code
    for (int c = 6; c < 16; c++) begin
      pins = 5'($random(seed));
      p2 = 3'(c / 2);
      ale = 1'b1;
      repeat (6) @(negedge clk);
      ale = 1'b0;
      chk({7'h00, tin}, {7'h00, pins[c / 2 - 3]});
      repeat (2) @(negedge clk);
    end
    $display("test setup done");
    run = 1'b1;
    upto(150);
    chk({6'h00, syn, olk}, 8'h02);
    k = nbe;
    upto(400);
    chk(8'(nbe - k), 8'h00);
    clr();
    upto(1500);
    acc(1'b0, pbet_pkg::EVT_ADDR, 8'h00);
    chk(rdata, evt(0, nblk(1500), 0));
    $display("test sync done");
    inj = 1'b1;
    upto(1600);
    k = nbe;
    upto(1760);
    // 160 bits hold exactly ten injected errors, each one true bit error
    chk(8'(nbe - k), 8'h0a);
    // three seconds, each with errors in it
    for (int s = 0; s < 3; s++) begin
      sec = 1'b1;
      repeat (100) @(negedge clk);
      sec = 1'b0;
      repeat (300) @(negedge clk);
    end
    upto(2500);
    inj = 1'b0;
    acc(1'b0, pbet_pkg::EVT_ADDR, 8'h00);
    // first injected bit is 1504, the first multiple of 16 after 1500
    chk(rdata, evt(3, nblk(2500), nblk(2500) - nblk(1504)));
    $display("test events done");
    hold = 1'b1;
    upto(2540);
    chk({6'h00, drop, olk}, 8'h03);
    hold = 1'b0;
    upto(2700);
    chk({6'h00, drop, olk}, 8'h02);
    clr();
    $display("test dropout done");
    run = 1'b0;
    pang = 1'b1;
    repeat (4) @(negedge clk);
    chk({5'h00, olk, cre, txd}, 8'h01);
    // five writes into a four-word buffer: the last is lost
    for (int i = 0; i < 5; i++) begin
      q.push_back(8'($random(seed)));
      acc(1'b1, pbet_pkg::CHAR_ADDR, q[i]);
    end
    for (int i = 0; i < 4; i++) begin
      k = 0;
      while (utx_v !== 1'b1 && k < 50) begin
        @(negedge clk);
        k++;
      end
      chk(utx_d, q[i]);
      utx_r = 1'b1;
      @(negedge clk);
      utx_r = 1'b0;
      @(negedge clk);
    end
    repeat (4) @(negedge clk);
    chk({7'h00, utx_v}, 8'h00);
    $display("test pangram done");
    pang = 1'b0;
    frm = 1'b1;
    dsel = 2'($random(seed));
    utx_r = 1'b1;
    run = 1'b1;
    repeat (4) @(negedge clk);
    chk({6'h00, cre, rdy}, 8'h01);
    urx_d = 8'($random(seed));
    urx_v = 1'b1;
    @(negedge clk);
    urx_v = 1'b0;
    chk({7'h00, rdy}, 8'h00);
    k = ntick;
    upto(k + 7 + dsel);
    chk({7'h00, rdy}, 8'h01);
    $display("test framed done");
    end_sim();
  end
endmodule
